// ---- rtl/tmr_pkg.sv ----
// package: register map, field positions and reset values of the ch11 compare block
package tmr_pkg;
   // address and counter widths
   localparam int unsigned AW    = 8;
   localparam int unsigned CNT_W = 16;

   // register byte offsets
   localparam logic [7:0] OFS_IO_CTRL = 8'h00;  // ch11_io_control
   localparam logic [7:0] OFS_ST11    = 8'h04;  // ch11_event_status
   localparam logic [7:0] OFS_IEN     = 8'h08;  // timer_irq_enable
   localparam logic [7:0] OFS_GR_A    = 8'h0c;  // general_reg_a
   localparam logic [7:0] OFS_GR_B    = 8'h10;  // general_reg_b
   localparam logic [7:0] OFS_CLR     = 8'h14;  // counter clear enables
   localparam logic [7:0] OFS_ST0     = 8'h18;  // ch0_event_status

   // field positions
   localparam int unsigned IO_BIT_A  = 0;       // cmp_enable_a
   localparam int unsigned IO_BIT_B  = 4;       // cmp_enable_b
   localparam int unsigned FLAG_CMA  = 0;       // compare-match a flag
   localparam int unsigned FLAG_CMB  = 1;       // compare-match b flag
   localparam int unsigned FLAG_OVF  = 2;       // counter overflow flag
   localparam int unsigned IEN_CH0_LSB = 8;     // ch0 enables start here

   // writable masks; other bits read zero
   localparam logic [7:0]  IO_WMASK  = 8'h11;
   localparam logic [7:0]  CLR_WMASK = 8'h11;
   localparam logic [15:0] ST11_MASK = 16'h0007;
   localparam logic [15:0] ST0_MASK  = 16'h00ff;
   localparam logic [15:0] IEN_MASK  = 16'hff07;

   // reset values
   localparam logic [7:0]  IO_RST  = 8'h00;
   localparam logic [7:0]  CLR_RST = 8'h00;
   localparam logic [15:0] ST_RST  = 16'h0000;
   localparam logic [15:0] IEN_RST = 16'h0000;
   localparam logic [15:0] GR_RST  = 16'hffff;
   localparam logic [31:0] RD_RST  = 32'h0000_0000;
endpackage

// ---- rtl/tmr_reg_if.sv ----
// interface: register access strobes between bus front end and register core
`timescale 1ns/1ps
interface tmr_reg_if;
   logic        wr_stb;  // write strobe, one cycle in access phase
   logic [7:0]  addr;    // byte address
   logic [31:0] wdata;   // write data
   logic [31:0] rdata;   // read data of addressed register
   logic        hit;     // address maps to a register

   modport apb  (output wr_stb, addr, wdata, input rdata, hit);
   modport core (input wr_stb, addr, wdata, output rdata, hit);
endinterface

// ---- rtl/tmr_apb_slave.sv ----
// module: apb slave front end, zero wait states, error on unmapped address
`timescale 1ns/1ps
module tmr_apb_slave
   import tmr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   tmr_reg_if.apb           rif
);
   logic [31:0] prdata_ff;  // read data held through access phase

   // address and data go straight to the core
   assign rif.addr   = paddr;
   assign rif.wdata  = pwdata;
   assign rif.wr_stb = psel & penable & pwrite & rif.hit;

   // read data sampled in setup so it is a flop in access
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         prdata_ff <= RD_RST;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= rif.rdata;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = psel & penable;             // never stalls
   assign pslverr = psel & penable & ~rif.hit;  // unmapped: no write
endmodule // tmr_apb_slave

// ---- rtl/tmr_cmp_unit.sv ----
// module: per-register compare of counter against general registers
`timescale 1ns/1ps
module tmr_cmp_unit
   import tmr_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rstn,
   input  wire logic [CNT_W-1:0]      cnt,
   input  wire logic [1:0][CNT_W-1:0] gr,
   input  wire logic [1:0]            en,
   output logic      [1:0]            hit
);
   logic [1:0] hit_ff;  // registered match pulses

   // one comparator per general register
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      always_ff @(posedge clk_sys) begin
         if (!rstn) begin
            hit_ff[i] <= 1'b0;
         end else begin
            hit_ff[i] <= en[i] & (cnt == gr[i]);  // disabled: never hits
         end
      end
   end

   assign hit = hit_ff;
endmodule // tmr_cmp_unit

// ---- rtl/tmr_ch11_top.sv ----
// module: ch11 compare control, status flags and interrupt requests
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tmr_ch11_top
   import tmr_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             hw_standby,
   input  wire logic             sw_standby,
   input  wire logic [CNT_W-1:0] frc_count,
   input  wire logic             frc_overflow,
   input  wire logic [7:0]       ch0_event_set,
   output logic                  counter_clear,
   output logic      [2:0]       irq_ch11,
   output logic      [7:0]       irq_ch0
);

   // ---- registers and wires ----
   logic             stby;           // either standby mode
   logic             init;           // reset or standby
   logic [7:0]       io_ctrl_ff;     // ch11_io_control
   logic [7:0]       clr_ctrl_ff;    // counter clear enables
   logic [15:0]      st11_ff;        // ch11_event_status
   logic [15:0]      st0_ff;         // ch0_event_status
   logic [15:0]      ien_ff;         // timer_irq_enable
   logic [CNT_W-1:0] gr_a_ff;        // general_reg_a
   logic [CNT_W-1:0] gr_b_ff;        // general_reg_b
   logic             clr_ff;         // counter clear pulse
   logic [2:0]       irq11_ff;       // ch11 requests
   logic [7:0]       irq0_ff;        // ch0 requests
   logic [1:0]       cmp_en;         // enables per register
   logic [1:0]       cmp_hit;        // match pulses
   logic [15:0]      nxt_st11;       // next ch11 status
   logic [15:0]      nxt_st0;        // next ch0 status
   logic [15:0]      keep11;         // bits kept by a write
   logic [15:0]      keep0;          // bits kept by a write
   logic [15:0]      set11;          // hardware set terms
   logic [15:0]      set0;           // hardware set terms
   logic             wr_io;          // write decodes
   logic             wr_st11;
   logic             wr_st0;
   logic             wr_ien;
   logic             wr_gra;
   logic             wr_grb;
   logic             wr_clr;

   tmr_reg_if rif ();

   // standby acts like a synchronous reset of the register file
   assign stby = hw_standby | sw_standby;
   assign init = ~rstn | stby;

   // ---- bus front end ----
   tmr_apb_slave u_apb (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rif     (rif.apb)
   );

   // ---- write decode ----
   assign wr_io   = rif.wr_stb & (rif.addr == OFS_IO_CTRL);
   assign wr_st11 = rif.wr_stb & (rif.addr == OFS_ST11);
   assign wr_st0  = rif.wr_stb & (rif.addr == OFS_ST0);
   assign wr_ien  = rif.wr_stb & (rif.addr == OFS_IEN);
   assign wr_gra  = rif.wr_stb & (rif.addr == OFS_GR_A);
   assign wr_grb  = rif.wr_stb & (rif.addr == OFS_GR_B);
   assign wr_clr  = rif.wr_stb & (rif.addr == OFS_CLR);

   // io control: only the two enable bits are stored
   always_ff @(posedge clk_sys) begin
      if (init) begin
         io_ctrl_ff <= IO_RST;
      end else if (wr_io) begin
         io_ctrl_ff <= rif.wdata[7:0] & IO_WMASK;
      end
   end

   // counter clear enables, same layout as the compare enables
   always_ff @(posedge clk_sys) begin
      if (init) begin
         clr_ctrl_ff <= CLR_RST;
      end else if (wr_clr) begin
         clr_ctrl_ff <= rif.wdata[7:0] & CLR_WMASK;
      end
   end

   // interrupt enables
   always_ff @(posedge clk_sys) begin
      if (init) begin
         ien_ff <= IEN_RST;
      end else if (wr_ien) begin
         ien_ff <= rif.wdata[15:0] & IEN_MASK;
      end
   end

   // general registers hold compare values
   always_ff @(posedge clk_sys) begin
      if (init) begin
         gr_a_ff <= GR_RST;
         gr_b_ff <= GR_RST;
      end else begin
         if (wr_gra) begin
            gr_a_ff <= rif.wdata[CNT_W-1:0];
         end
         if (wr_grb) begin
            gr_b_ff <= rif.wdata[CNT_W-1:0];
         end
      end
   end

   // ---- compare ----
   assign cmp_en[0] = io_ctrl_ff[IO_BIT_A];
   assign cmp_en[1] = io_ctrl_ff[IO_BIT_B];

   tmr_cmp_unit u_cmp (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .cnt     (frc_count),
      .gr      ({gr_b_ff, gr_a_ff}),
      .en      (cmp_en),
      .hit     (cmp_hit)
   );

   // ---- status flags ----
   // writing 0 clears a flag, writing 1 leaves it; a set in the
   // same cycle beats the clear so no event is lost
   always_comb begin
      keep11 = wr_st11 ? rif.wdata[15:0] : 16'hffff;
      keep0  = wr_st0  ? rif.wdata[15:0] : 16'hffff;
      set11  = 16'h0000;
      set11[FLAG_CMA] = cmp_hit[0];
      set11[FLAG_CMB] = cmp_hit[1];
      set11[FLAG_OVF] = frc_overflow;
      set0   = {8'h00, ch0_event_set};
      nxt_st11 = ((st11_ff & keep11) | set11) & ST11_MASK;
      nxt_st0  = ((st0_ff & keep0) | set0) & ST0_MASK;
   end

   always_ff @(posedge clk_sys) begin
      if (init) begin
         st11_ff <= ST_RST;
         st0_ff  <= ST_RST;
      end else begin
         st11_ff <= nxt_st11;
         st0_ff  <= nxt_st0;
      end
   end

   // ---- interrupt requests ----
   // one request line per flag, gated by its enable bit
   always_ff @(posedge clk_sys) begin
      if (init) begin
         irq11_ff <= 3'h0;
         irq0_ff  <= 8'h00;
      end else begin
         irq11_ff <= st11_ff[2:0] & ien_ff[2:0];
         irq0_ff  <= st0_ff[7:0] & ien_ff[IEN_CH0_LSB +: 8];
      end
   end

   assign irq_ch11 = irq11_ff;
   assign irq_ch0  = irq0_ff;

   // ---- counter clear ----
   // a hit exists only while its compare is enabled, so a register
   // that is not comparing can never clear the counter
   always_ff @(posedge clk_sys) begin
      if (init) begin
         clr_ff <= 1'b0;
      end else begin
         clr_ff <= (cmp_hit[0] & clr_ctrl_ff[IO_BIT_A])
                 | (cmp_hit[1] & clr_ctrl_ff[IO_BIT_B]);
      end
   end

   assign counter_clear = clr_ff;

   // ---- read mux ----
   always_comb begin
      rif.rdata = 32'h0000_0000;
      rif.hit   = 1'b1;
      case (rif.addr)
         OFS_IO_CTRL: rif.rdata = {24'h00_0000, io_ctrl_ff};
         OFS_ST11:    rif.rdata = {16'h0000, st11_ff};
         OFS_ST0:     rif.rdata = {16'h0000, st0_ff};
         OFS_IEN:     rif.rdata = {16'h0000, ien_ff};
         OFS_GR_A:    rif.rdata = {16'h0000, gr_a_ff};
         OFS_GR_B:    rif.rdata = {16'h0000, gr_b_ff};
         OFS_CLR:     rif.rdata = {24'h00_0000, clr_ctrl_ff};
         default:     rif.hit   = 1'b0;                    // unmapped
      endcase
   end

   // ---- assertions ----
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_io_clear;
      stby |=> (io_ctrl_ff == IO_RST) && (clr_ctrl_ff == CLR_RST);
   endproperty
   a_io_clear: assert property (p_io_clear)
      else $error("io control not cleared by standby");

   property p_io_rsvd;
      (rif.addr == OFS_IO_CTRL) |-> (rif.rdata[7:5] == 3'h0)
                                    && (rif.rdata[3:1] == 3'h0);
   endproperty
   a_io_rsvd: assert property (p_io_rsvd)
      else $error("io control reserved bits read nonzero");

   property p_io_write;
      wr_io && !stby |=> io_ctrl_ff == ($past(rif.wdata[7:0]) & IO_WMASK);
   endproperty
   a_io_write: assert property (p_io_write)
      else $error("io control write not stored");

   property p_hit_b;
      cmp_hit[1] |-> $past(io_ctrl_ff[IO_BIT_B]) && $past(frc_count == gr_b_ff);
   endproperty
   a_hit_b: assert property (p_hit_b)
      else $error("b match without enable or equality");

   property p_hit_a;
      cmp_hit[0] |-> $past(io_ctrl_ff[IO_BIT_A]) && $past(frc_count == gr_a_ff);
   endproperty
   a_hit_a: assert property (p_hit_a)
      else $error("a match without enable or equality");

   property p_st_wclr;
      wr_st11 && !rif.wdata[FLAG_OVF] && !frc_overflow && !stby
         |=> !st11_ff[FLAG_OVF];
   endproperty
   a_st_wclr: assert property (p_st_wclr)
      else $error("status flag not cleared by writing zero");

   property p_ovf_set;
      frc_overflow && !stby |=> st11_ff[FLAG_OVF];
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow did not set its flag");

   property p_irq;
      st11_ff[FLAG_CMA] && ien_ff[FLAG_CMA] && !stby ##1 !stby
         |-> irq_ch11[FLAG_CMA];
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled flag raised no request");

   property p_irq_gate;
      irq_ch11[FLAG_OVF] |-> $past(ien_ff[FLAG_OVF]);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("request without enable");

   property p_st_clear;
      stby |=> (st11_ff == ST_RST) && (st0_ff == ST_RST);
   endproperty
   a_st_clear: assert property (p_st_clear)
      else $error("status not cleared by standby");

   property p_clr_gate;
      counter_clear |-> ##0 $past(cmp_hit != 2'b00) ##0 $past(io_ctrl_ff, 2) != IO_RST;
   endproperty
   a_clr_gate: assert property (p_clr_gate)
      else $error("counter clear without enabled compare");

   sequence s_match_a;
      io_ctrl_ff[IO_BIT_A] && (frc_count == gr_a_ff) && !stby ##1 !stby [*2];
   endsequence
   property p_match_a;
      s_match_a |-> st11_ff[FLAG_CMA];
   endproperty
   a_match_a: assert property (p_match_a)
      else $error("enabled match did not set flag a");

   // same path for register b, so a swapped enable bit shows up here
   sequence s_match_b;
      io_ctrl_ff[IO_BIT_B] && (frc_count == gr_b_ff) && !stby ##1 !stby [*2];
   endsequence
   property p_match_b;
      s_match_b |-> st11_ff[FLAG_CMB];
   endproperty
   a_match_b: assert property (p_match_b)
      else $error("enabled match did not set flag b");

   // control bits move only by a bus write or by reset and standby
   property p_io_hold;
      !wr_io && !stby |=> $stable(io_ctrl_ff);
   endproperty
   a_io_hold: assert property (p_io_hold)
      else $error("io control changed without a write");

   // overflow request follows its flag once the enable is set
   property p_ovf_irq;
      st11_ff[FLAG_OVF] && ien_ff[FLAG_OVF] && !stby |=> irq_ch11[FLAG_OVF];
   endproperty
   a_ovf_irq: assert property (p_ovf_irq)
      else $error("enabled overflow flag raised no request");

   // no ch0 request line may rise while its enable was clear
   property p_irq0_gate;
      irq_ch0 != 8'h00 |-> (irq_ch0 & ~$past(ien_ff[IEN_CH0_LSB +: 8])) == 8'h00;
   endproperty
   a_irq0_gate: assert property (p_irq0_gate)
      else $error("ch0 request without enable");

   // every ch0 event pulse must land in its status bit
   property p_st0_set;
      (ch0_event_set != 8'h00) && !stby
         |=> (st0_ff[7:0] & $past(ch0_event_set)) == $past(ch0_event_set);
   endproperty
   a_st0_set: assert property (p_st0_set)
      else $error("ch0 event did not set its flag");

   c_write_io:  cover property (wr_io ##1 io_ctrl_ff[IO_BIT_B]);
   c_irq:       cover property ($rose(irq_ch11[FLAG_CMB]));
   c_clear:     cover property (counter_clear);
   c_set_clear: cover property (wr_st11 && cmp_hit[0]);

endmodule // tmr_ch11_top

// ---- dv/tmr_ch11_top_bench.sv ----
// testbench: register model, compare, status, standby and bus error checks of the ch11 block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module tmr_ch11_top_bench
   import tmr_pkg::*;
;
   logic             clk_sys = 1'b0;   // 40 MHz system clock
   logic             rstn;             // sync reset, active low
   logic             psel, penable, pwrite;
   logic [7:0]       paddr;
   logic [31:0]      pwdata, prdata;
   logic             pready, pslverr;
   logic             hw_standby, sw_standby;
   logic [CNT_W-1:0] frc_count;        // idles at zero, general regs kept odd
   logic             frc_overflow;
   logic [7:0]       ch0_event_set;
   logic             counter_clear;
   logic [2:0]       irq_ch11;
   logic [7:0]       irq_ch0;
   logic [31:0]      mdl [0:6];        // model of each register word
   int               n_fail = 0, checked = 0, n_clr = 0, exp_clr = 0, seed = 4;

   always #12.5 clk_sys = ~clk_sys;

   tmr_ch11_top dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_standby(hw_standby), .sw_standby(sw_standby),
      .frc_count(frc_count), .frc_overflow(frc_overflow), .ch0_event_set(ch0_event_set),
      .counter_clear(counter_clear), .irq_ch11(irq_ch11), .irq_ch0(irq_ch0));

   // count clear pulses; a held pulse would show as a surplus
   always @(posedge clk_sys) begin
      if (counter_clear === 1'b1) n_clr <= n_clr + 1;
   end

   // closing report, the single exit of the run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // writable bits of each register word
   function automatic logic [31:0] wmask(int i);
      case (i)
         0: return {24'h0, IO_WMASK};
         1: return {16'h0, ST11_MASK};
         2: return {16'h0, IEN_MASK};
         3, 4: return 32'h0000_ffff;
         5: return {24'h0, CLR_WMASK};
         default: return {16'h0, ST0_MASK};
      endcase
   endfunction

   // model reset: power-on and both standby modes alike
   task automatic mdl_rst();
      mdl[0] = {24'h0, IO_RST};
      mdl[1] = {16'h0, ST_RST};
      mdl[2] = {16'h0, IEN_RST};
      mdl[3] = {16'h0, GR_RST};
      mdl[4] = {16'h0, GR_RST};
      mdl[5] = {24'h0, CLR_RST};
      mdl[6] = {16'h0, ST_RST};
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 16) begin
         n_fail++;
         end_sim();
      end
   endtask

   // write and update the model; status words only clear where a zero is written
   task automatic wr(input int i, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, 8'(i * 4), d, q, e);
      `CHK("wr_err", 1'b0, e)
      if (i == 1 || i == 6) mdl[i] = mdl[i] & d & wmask(i);
      else mdl[i] = d & wmask(i);
   endtask

   // read one word and compare it and the interrupt lines with the model
   task automatic rd(input int i);
      logic [31:0] q;
      logic        e;
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      `CHK("prdata", mdl[i], q)
      `CHK("rd_err", 1'b0, e)
      `CHK("irq_ch11", mdl[1][2:0] & mdl[2][2:0], irq_ch11)
      `CHK("irq_ch0", mdl[6][7:0] & mdl[2][15:8], irq_ch0)
   endtask

   task automatic rd_all();
      for (int i = 0; i < 7; i++) rd(i);
   endtask

   // one cycle of counter equal to general register b (0 = a, 1 = b)
   task automatic match(input int b);
      @(posedge clk_sys);
      frc_count <= mdl[3 + b][15:0];
      @(posedge clk_sys);
      frc_count <= '0;
      repeat (4) @(posedge clk_sys);
      if (mdl[0][b ? IO_BIT_B : IO_BIT_A]) begin
         mdl[1][b] = 1'b1;
         if (mdl[5][4 * b]) exp_clr++;
      end
   endtask

   // one-cycle overflow and ch0 event pulses
   task automatic ev(input logic ovf, input logic [7:0] v);
      @(posedge clk_sys);
      frc_overflow <= ovf; ch0_event_set <= v;
      @(posedge clk_sys);
      frc_overflow <= 1'b0; ch0_event_set <= 8'h00;
      repeat (3) @(posedge clk_sys);
      mdl[1][FLAG_OVF] = mdl[1][FLAG_OVF] | ovf;
      mdl[6][7:0] = mdl[6][7:0] | v;
   endtask

   initial begin
      logic [31:0] q, d;
      logic        e;
      int          k;
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; hw_standby = 1'b0; sw_standby = 1'b0; frc_count = '0;
      frc_overflow = 1'b0; ch0_event_set = 8'h00;
      mdl_rst();
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_all();
      apb(1'b0, 8'h1c, 32'h0, q, e);  // unmapped word: refused, reads zero
      `CHK("unmapped_err", 1'b1, e)
      `CHK("unmapped_data", 32'h0, q)
      $display("test reset done");
      // random writes; reserved io control bits are written zero and must read back zero
      for (int n = 0; n < 24; n++) begin
         k = {$random(seed)} % 7;
         d = $random(seed);
         if (k == 0) d = d & {24'h0, IO_WMASK};
         if (k == 3 || k == 4) d[0] = 1'b1;  // keep clear of idle count
         wr(k, d);
         rd(k);
      end
      $display("test registers done");
      // compare a enabled, b disabled, then the other way round, then both enabled with only b clearing the counter
      wr(2, 32'h0000_ff07); wr(5, 32'h11); wr(1, 0); wr(6, 0);
      wr(3, $random(seed) | 1); wr(4, $random(seed) | 1);
      wr(0, 32'h01); match(0); match(1); rd(1);
      wr(1, 0); wr(0, 32'h10); match(0); match(1); rd(1);
      wr(0, 32'h11); wr(5, 32'h10); match(0); match(1); rd_all();
      `CHK("clr_count", exp_clr, n_clr)
      $display("test compare done");
      // overflow and ch0 events, masked and unmasked; flag a and ch0 bits 7:4 cleared by zero writes
      wr(2, 32'h0000_0003); ev(1'b1, 8'($random(seed))); rd_all();
      wr(2, 32'h0000_ff04); rd(1); rd(6);
      wr(1, 32'h0000_fffe); wr(6, 32'h0000_ff0f); rd_all();
      $display("test status done");
      // each standby mode clears control and status words
      for (int s = 0; s < 2; s++) begin
         wr(0, 32'h11); wr(2, 32'h0000_ff07); ev(1'b1, 8'hff); match(0);
         @(posedge clk_sys);
         if (s == 0) hw_standby <= 1'b1; else sw_standby <= 1'b1;
         @(posedge clk_sys);
         hw_standby <= 1'b0; sw_standby <= 1'b0;
         repeat (2) @(posedge clk_sys);
         mdl_rst();
         rd_all();
      end
      $display("test standby done");
      end_sim();
   end
endmodule // tmr_ch11_top_bench
